// ---- iprf_params.svh ----
// Register offsets, field positions and reset values of the interrupt regs.
`ifndef IPRF_PARAMS_SVH
`define IPRF_PARAMS_SVH

`define IPRF_OFF_CPU_STATUS 12'h000
`define IPRF_OFF_CORE_CONTROL 12'h004
`define IPRF_OFF_IRQ_CONTROL_ONE 12'h008
`define IPRF_OFF_IRQ_CONTROL_TWO 12'h00C
`define IPRF_OFF_IRQ_FLAGS_BANK0 12'h010
`define IPRF_OFF_EVT_STATUS 12'h014
`define IPRF_OFF_EVT_MASK 12'h018

`define IPRF_POS_PRIO_LOW 5
`define IPRF_POS_PRIO_HIGH 3
`define IPRF_POS_NESTING_OFF 15
`define IPRF_POS_DIV_ZERO 6
`define IPRF_POS_DMA_CTRL 5
`define IPRF_POS_MATH 4
`define IPRF_POS_ADDR 3
`define IPRF_POS_STACK 2
`define IPRF_POS_OSC_FAIL 1
`define IPRF_POS_ALT_TABLE 15
`define IPRF_POS_HOLD_ACTIVE 14
`define IPRF_POS_EDGE_POL 0

`define IPRF_RST_PRIO_LOW 3'h0
`define IPRF_RST_PRIO_HIGH 1'h0
`define IPRF_RST_FLAG 1'h0
`define IPRF_RST_EDGE_POL 5'h00
`define IPRF_RST_FLAGS_BANK0 15'h0000
`define IPRF_RST_EVT 3'h0
`define IPRF_MAX_LOW_PRIO 4'h7

`endif

// ---- iprf_pkg.sv ----
// Types shared by the interrupt priority and flag register block.
package iprf_pkg;
    typedef logic [15:0] iprf_word_t;
    typedef logic [3:0] iprf_prio_t;
    // Index of each trap source in the trap event vector.
    typedef enum logic [2:0] {
        IPRF_TRAP_OSC = 3'h0,
        IPRF_TRAP_STACK = 3'h1,
        IPRF_TRAP_ADDR = 3'h2,
        IPRF_TRAP_MATH = 3'h3,
        IPRF_TRAP_DMA = 3'h4
    } iprf_trap_t;
endpackage

// ---- iprf_top.sv ----
// Interrupt priority, trap status and request flag registers on APB.
`timescale 1ns/1ns
`include "iprf_params.svh"

module iprf_top
    import iprf_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU core side.
    input wire logic core_prio_load,
    input wire logic [3:0] core_prio_value,
    input wire logic irq_hold_in,
    input wire logic [4:0] trap_event,
    input wire logic trap_div_zero,
    input wire logic pend_valid,
    input wire logic [2:0] pend_prio,
    output logic pend_accept,
    output logic [3:0] cpu_prio_eff,
    output logic nesting_off,
    output logic alt_table_select,
    output logic [4:0] ext_edge_pol,
    output logic [5:0] trap_flags,
    // Peripheral and external request sources.
    input wire logic [14:0] req_pulse,
    output logic [14:0] req_flags,
    // Interrupt line.
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic wr_en;
    logic rd_setup;
    logic hit_status;
    logic hit_core;
    logic hit_one;
    logic hit_two;
    logic hit_flags;
    logic hit_evt;
    logic hit_mask;
    logic hit_any;
    iprf_word_t wdata;

    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign wdata = pwdata[15:0];
    assign hit_status = paddr == `IPRF_OFF_CPU_STATUS;
    assign hit_core = paddr == `IPRF_OFF_CORE_CONTROL;
    assign hit_one = paddr == `IPRF_OFF_IRQ_CONTROL_ONE;
    assign hit_two = paddr == `IPRF_OFF_IRQ_CONTROL_TWO;
    assign hit_flags = paddr == `IPRF_OFF_IRQ_FLAGS_BANK0;
    assign hit_evt = paddr == `IPRF_OFF_EVT_STATUS;
    assign hit_mask = paddr == `IPRF_OFF_EVT_MASK;
    assign hit_any = hit_status | hit_core | hit_one | hit_two | hit_flags
        | hit_evt | hit_mask;
    // Every access completes in its first access cycle.
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // CPU priority.

    logic [2:0] prio_low_reg;
    logic prio_high_reg;
    logic nesting_off_reg;

    // The core's own load wins over a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_low_reg <= `IPRF_RST_PRIO_LOW;
        end else if (core_prio_load) begin
            prio_low_reg <= core_prio_value[2:0];
        end else if (wr_en && hit_status && !nesting_off_reg) begin
            prio_low_reg <= wdata[`IPRF_POS_PRIO_LOW +: 3];
        end
    end

    // Software may only clear the high bit; only the core can raise it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_high_reg <= `IPRF_RST_PRIO_HIGH;
        end else if (core_prio_load) begin
            prio_high_reg <= core_prio_value[3];
        end else if (wr_en && hit_core && !wdata[`IPRF_POS_PRIO_HIGH]) begin
            prio_high_reg <= 1'b0;
        end
    end

    assign cpu_prio_eff = {prio_high_reg, prio_low_reg};
    // Level 7 or any level with the high bit set is never exceeded.
    assign pend_accept = pend_valid
        && ({1'b0, pend_prio} > cpu_prio_eff);

    ////////////////////////////////////////////////////////////////////////
    // Control register one: nesting disable and trap flags.

    logic [5:0] trap_reg;
    logic [5:0] trap_set;
    logic [5:0] trap_wval;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nesting_off_reg <= `IPRF_RST_FLAG;
        end else if (wr_en && hit_one) begin
            nesting_off_reg <= wdata[`IPRF_POS_NESTING_OFF];
        end
    end

    // Bit order of trap_reg: osc, stack, addr, math, dma, div-zero.
    assign trap_set = {trap_event[IPRF_TRAP_MATH] & trap_div_zero,
                       trap_event[IPRF_TRAP_DMA],
                       trap_event[IPRF_TRAP_MATH],
                       trap_event[IPRF_TRAP_ADDR],
                       trap_event[IPRF_TRAP_STACK],
                       trap_event[IPRF_TRAP_OSC]};
    assign trap_wval = wdata[`IPRF_POS_DIV_ZERO:`IPRF_POS_OSC_FAIL];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_reg <= {6{`IPRF_RST_FLAG}};
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (trap_set[i]) begin
                    trap_reg[i] <= 1'b1;
                end else if (i == 5 && trap_event[IPRF_TRAP_MATH]) begin
                    // A math trap not caused by division leaves it clear.
                    trap_reg[i] <= 1'b0;
                end else if (wr_en && hit_one) begin
                    trap_reg[i] <= trap_wval[i];
                end
            end
        end
    end

    assign nesting_off = nesting_off_reg;
    assign trap_flags = trap_reg;

    ////////////////////////////////////////////////////////////////////////
    // Control register two.

    logic alt_table_reg;
    logic [4:0] edge_pol_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_table_reg <= `IPRF_RST_FLAG;
            edge_pol_reg <= `IPRF_RST_EDGE_POL;
        end else if (wr_en && hit_two) begin
            alt_table_reg <= wdata[`IPRF_POS_ALT_TABLE];
            edge_pol_reg <= wdata[`IPRF_POS_EDGE_POL +: 5];
        end
    end

    assign alt_table_select = alt_table_reg;
    assign ext_edge_pol = edge_pol_reg;

    ////////////////////////////////////////////////////////////////////////
    // Request flag bank: a source pulse wins over a software clear.

    logic [14:0] flags_reg;

    generate
        for (genvar g = 0; g < 15; g++) begin : gen_flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags_reg[g] <= `IPRF_RST_FLAG;
                end else if (req_pulse[g]) begin
                    flags_reg[g] <= 1'b1;
                end else if (wr_en && hit_flags) begin
                    flags_reg[g] <= wdata[g];
                end
            end
        end
    endgenerate

    assign req_flags = flags_reg;

    ////////////////////////////////////////////////////////////////////////
    // Event status, mask and interrupt line.
    // Bit 0: any trap, bit 1: any request, bit 2: pending accepted.

    logic [2:0] evt_reg;
    logic [2:0] mask_reg;
    logic [2:0] evt_set;
    logic [2:0] evt_clr;
    logic [2:0] evt_next;
    logic [2:0] mask_next;

    assign evt_set = {pend_accept, |req_pulse, |trap_event};

    // A new event wins over a write-one-to-clear in the same cycle.
    always_comb begin
        evt_clr = 3'h0;
        if (wr_en && hit_evt) begin
            evt_clr = wdata[2:0];
        end
        evt_next = evt_set | (evt_reg & ~evt_clr);
    end

    always_comb begin
        mask_next = mask_reg;
        if (wr_en && hit_mask) begin
            mask_next = wdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_reg <= `IPRF_RST_EVT;
        end else begin
            evt_reg <= evt_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= `IPRF_RST_EVT;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // Built from the next values so that the line follows the status and
    // mask registers exactly, with no extra cycle after a clear or unmask.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_next & mask_next);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle.

    iprf_word_t rd_word;

    always_comb begin
        rd_word = 16'h0000;
        if (hit_status) begin
            rd_word[`IPRF_POS_PRIO_LOW +: 3] = prio_low_reg;
        end
        if (hit_core) begin
            rd_word[`IPRF_POS_PRIO_HIGH] = prio_high_reg;
        end
        if (hit_one) begin
            rd_word[`IPRF_POS_NESTING_OFF] = nesting_off_reg;
            rd_word[`IPRF_POS_DIV_ZERO:`IPRF_POS_OSC_FAIL] = trap_reg;
        end
        if (hit_two) begin
            rd_word[`IPRF_POS_ALT_TABLE] = alt_table_reg;
            rd_word[`IPRF_POS_HOLD_ACTIVE] = irq_hold_in;
            rd_word[`IPRF_POS_EDGE_POL +: 5] = edge_pol_reg;
        end
        if (hit_flags) begin
            rd_word[14:0] = flags_reg;
        end
        if (hit_evt) begin
            rd_word[2:0] = evt_reg;
        end
        if (hit_mask) begin
            rd_word[2:0] = mask_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= {16'h0000, rd_word};
            pslverr <= ~hit_any;
        end
    end

endmodule

// ---- iprf_top_sva.sv ----
// Assertion checker for the interrupt priority and flag registers.
`timescale 1ns/1ns
module iprf_chk (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // Core and request sources.
    input wire logic core_prio_load,
    input wire logic [3:0] core_prio_value,
    input wire logic [4:0] trap_event,
    input wire logic trap_div_zero,
    input wire logic pend_valid,
    input wire logic [2:0] pend_prio,
    input wire logic pend_accept,
    input wire logic [3:0] cpu_prio_eff,
    input wire logic nesting_off,
    input wire logic [5:0] trap_flags,
    input wire logic [14:0] req_pulse,
    input wire logic [14:0] req_flags,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_accept_above: assert property (pend_accept ==
        (pend_valid && {1'b0, pend_prio} > cpu_prio_eff))
        else $error("bad accept");
    a_high_blocks: assert property (cpu_prio_eff[3] |->
        !pend_accept) else $error("accept above level 7");
    a_core_load: assert property (core_prio_load |=>
        cpu_prio_eff == $past(core_prio_value)) else $error("load missed");
    a_nest_lock: assert property (nesting_off && !core_prio_load |=>
        $stable(cpu_prio_eff[2:0])) else $error("level moved while locked");
    a_high_rise: assert property ($rose(cpu_prio_eff[3]) |->
        $past(core_prio_load)) else $error("high bit set without load");
    a_req_set: assert property (|req_pulse |=>
        (req_flags & $past(req_pulse)) == $past(req_pulse)) else $error("req");
    a_flags_hold: assert property (!(psel && penable && pwrite) |=>
        (req_flags & $past(req_flags)) == $past(req_flags))
        else $error("lost");
    a_trap_set: assert property (|trap_event |=>
        (trap_flags[4:0] & $past(trap_event)) == $past(trap_event))
        else $error("trap flag missed");
    a_div_zero: assert property (trap_event[3] && trap_div_zero |=>
        trap_flags[5]) else $error("divide flag missed");
    c_high_load: cover property (core_prio_load && core_prio_value[3]);
    c_accept: cover property (pend_accept);
    c_irq: cover property ($rose(irq));
endmodule
bind iprf_top iprf_chk u_iprf_chk (.*);

// ---- iprf_src_model.sv ----
// Behavioural core and request sources facing the register block.
`timescale 1ns/1ns
module iprf_src_model (
    // Clock.
    input wire logic pclk,
    // Core and sources.
    output logic core_prio_load,
    output logic [3:0] core_prio_value,
    output logic irq_hold_in,
    output logic [4:0] trap_event,
    output logic trap_div_zero,
    output logic pend_valid,
    output logic [2:0] pend_prio,
    output logic [14:0] req_pulse
);
    initial {core_prio_load, core_prio_value, irq_hold_in, trap_event,
        trap_div_zero, pend_valid, pend_prio, req_pulse} = '0;
    // Sources pulse for one cycle only; the block must keep the flag.
    task automatic fire(input logic [14:0] rq, input logic [4:0] tr,
        input logic dz);
        @(posedge pclk);
        req_pulse <= rq;
        trap_event <= tr;
        trap_div_zero <= dz;
        @(posedge pclk);
        req_pulse <= 15'h0000;
        trap_event <= 5'h00;
        trap_div_zero <= 1'b0;
    endtask
    task automatic load(input logic [3:0] v);
        @(posedge pclk);
        core_prio_load <= 1'b1;
        core_prio_value <= v;
        @(posedge pclk);
        core_prio_load <= 1'b0;
        core_prio_value <= ~v;
    endtask
    task automatic level(input logic h, input logic pv, input logic [2:0] pp);
        @(posedge pclk);
        irq_hold_in <= h;
        pend_valid <= pv;
        pend_prio <= pp;
    endtask
endmodule

// ---- test_interrupt_priority_and_flag_regs.sv ----
// Self-checking bench for the interrupt priority and flag registers.
`timescale 1ns/1ns
`include "iprf_params.svh"
module test_interrupt_priority_and_flag_regs import iprf_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, e, core_prio_load, irq_hold_in;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic trap_div_zero, pend_valid, pend_accept, nesting_off, irq;
    logic alt_table_select;
    logic [2:0] pend_prio, p;
    logic [3:0] core_prio_value, cpu_prio_eff;
    logic [4:0] trap_event, ext_edge_pol;
    logic [5:0] trap_flags;
    logic [14:0] req_pulse, req_flags, rq;
    int n_fail = 0, checks_done = 0, cyc = 0, tr = 0, fl = 0;
    int seed = 32'h935C;
    iprf_top u_iprf_top (.*);
    iprf_src_model u_iprf_src_model (.*);
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), x, r);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 16; a += 4) rd(a[11:0], 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `IPRF_OFF_CPU_STATUS, i << 5);
            rd(`IPRF_OFF_CPU_STATUS, i << 5);
            p = 3'($random(seed));
            u_iprf_src_model.level(1'b0, 1'b1, p);
            @(negedge pclk);
            chk("accept", 32'(p > i), 32'(pend_accept));
        end
        apb(1'b1, `IPRF_OFF_CORE_CONTROL, 32'h8);
        rd(`IPRF_OFF_CORE_CONTROL, 32'h0);
        u_iprf_src_model.load(4'hA);
        u_iprf_src_model.level(1'b0, 1'b1, 3'h7);
        @(negedge pclk);
        chk("eff", 32'hA, 32'(cpu_prio_eff));
        chk("blocked", 32'h0, 32'(pend_accept));
        rd(`IPRF_OFF_CORE_CONTROL, 32'h8);
        rd(`IPRF_OFF_CPU_STATUS, 32'h40);
        apb(1'b1, `IPRF_OFF_CORE_CONTROL, 32'h0);
        @(negedge pclk);
        chk("accept", 32'h1, 32'(pend_accept));
        apb(1'b1, `IPRF_OFF_IRQ_CONTROL_ONE, 32'h8000);
        apb(1'b1, `IPRF_OFF_CPU_STATUS, 32'hE0);
        rd(`IPRF_OFF_CPU_STATUS, 32'h40);
        chk("nest", 32'h1, 32'(nesting_off));
        apb(1'b1, `IPRF_OFF_IRQ_CONTROL_ONE, 32'hFFFF);
        rd(`IPRF_OFF_IRQ_CONTROL_ONE, 32'h807E);
        apb(1'b1, `IPRF_OFF_IRQ_CONTROL_ONE, 32'h0);
        for (int i = 0; i < 5; i++) begin
            u_iprf_src_model.fire(15'h0, 5'(1 << i), i == 3);
            tr = tr | (2 << i) | ((i == 3) ? 32'h40 : 0);
            rd(`IPRF_OFF_IRQ_CONTROL_ONE, tr);
        end
        u_iprf_src_model.fire(15'h0, 5'h08, 1'b0);
        rd(`IPRF_OFF_IRQ_CONTROL_ONE, tr & 32'h3E);
        chk("trap out", 32'h1F, 32'(trap_flags));
        u_iprf_src_model.level(1'b1, 1'b0, 3'h0);
        apb(1'b1, `IPRF_OFF_IRQ_CONTROL_TWO, 32'hFFFF);
        rd(`IPRF_OFF_IRQ_CONTROL_TWO, 32'hC01F);
        chk("ctl2", 32'h3F, 32'({alt_table_select, ext_edge_pol}));
        repeat (4) begin
            rq = 15'($random(seed));
            u_iprf_src_model.fire(rq, 5'h00, 1'b0);
            fl = fl | rq;
            rd(`IPRF_OFF_IRQ_FLAGS_BANK0, fl);
        end
        apb(1'b1, `IPRF_OFF_IRQ_FLAGS_BANK0, 32'hFFFF);
        rd(`IPRF_OFF_IRQ_FLAGS_BANK0, 32'h7FFF);
        chk("req out", 32'h7FFF, 32'(req_flags));
        apb(1'b1, `IPRF_OFF_IRQ_FLAGS_BANK0, 32'h0);
        rd(`IPRF_OFF_IRQ_FLAGS_BANK0, 32'h0);
        chk("irq masked", 32'h0, 32'(irq));
        rd(`IPRF_OFF_EVT_STATUS, 32'h7);
        apb(1'b1, `IPRF_OFF_EVT_MASK, 32'h2);
        repeat (2) @(negedge pclk);
        chk("irq on", 32'h1, 32'(irq));
        apb(1'b1, `IPRF_OFF_EVT_STATUS, 32'h2);
        repeat (2) @(negedge pclk);
        chk("irq off", 32'h0, 32'(irq));
        rd(`IPRF_OFF_EVT_STATUS, 32'h5);
        print_verdict();
    end
endmodule
